// ### logic/sac_pkg.sv
// Constants and types for the converter control block
package sac_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_REF = 8'h04;
  localparam logic [7:0] ADDR_MUX = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_ISTAT = 8'h10;
  localparam logic [7:0] ADDR_ICLR = 8'h14;
  localparam logic [7:0] ADDR_IEN = 8'h18;
  localparam logic [7:0] ADDR_COUNT = 8'h1c;
  // Field positions
  localparam int CTRL_BME_BIT = 0;
  localparam int CTRL_BUSY_BIT = 1;
  localparam int CTRL_DIV_LSB = 8;
  localparam int DIV_W = 5;
  localparam int REF_SEL_LSB = 0;
  localparam int REF_GND_BIT = 2;
  localparam int REF_LVL_BIT = 3;
  localparam int MUX_LSB = 0;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_RSVD_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int CNT_W = 5;
  // Reset values
  localparam logic [DIV_W-1:0] DIV_RST = 5'h1f;
  localparam logic RST_BME = 1'b0;
  localparam logic [1:0] REF_RST = 2'h1;
  localparam logic GND_SEL_RST = 1'b0;
  localparam logic LVL_RST = 1'b0;
  localparam logic [4:0] MUX_RST = 5'h1f;
  localparam logic [IRQ_W-1:0] IEN_RST = 2'h0;
  // Reference sources
  localparam logic [1:0] REF_EXT = 2'h0;
  localparam logic [1:0] REF_VDD = 2'h1;
  localparam logic [1:0] REF_LDO = 2'h2;
  localparam logic [1:0] REF_INT = 2'h3;
  // Internal reference level: 1.65 V or 2.4 V
  localparam logic LVL_1V65 = 1'b0;
  localparam logic LVL_2V4 = 1'b1;
  // Ground sources
  localparam logic [1:0] GND_PIN = 2'h0;
  localparam logic [1:0] GND_APIN = 2'h1;
  localparam logic [1:0] GND_CHIP = 2'h2;
  // Input select codes
  localparam logic [4:0] CH_EXT_LAST = 5'h0e;
  localparam logic [4:0] CH_TEMP = 5'h10;
  localparam logic [4:0] CH_LDO = 5'h11;
  localparam logic [4:0] CH_VDD = 5'h12;
  localparam logic [4:0] CH_GND = 5'h13;
  localparam logic [4:0] CH_P2 = 5'h18;
  localparam logic [4:0] CH_DP = 5'h1c;
  localparam logic [4:0] CH_DM = 5'h1d;
  localparam logic [4:0] CH_VQ = 5'h1e;
  localparam logic [4:0] CH_NONE = 5'h1f;
  // Timing in conversion clocks
  localparam int TRACK_CLKS_DEF = 4;
  localparam int RES_BITS_DEF = 12;

  typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV} sac_state_t;
endpackage : sac_pkg

// ### logic/sac_div_if.sv
// Link between the controller and its conversion clock divider
`timescale 1ns/1ps
interface sac_div_if;
  import sac_pkg::*;
  logic burst_mode_enable;
  logic [DIV_W-1:0] conversion_clock_divider;
  logic fast_osc_raw;
  logic tick;
  modport ctl (
    output burst_mode_enable,
    output conversion_clock_divider,
    output fast_osc_raw,
    input tick
  );
  modport div (
    input burst_mode_enable,
    input conversion_clock_divider,
    input fast_osc_raw,
    output tick
  );
endinterface : sac_div_if

// ### logic/sac_clk_div.sv
// Conversion clock enable divider with fast oscillator sampling
`timescale 1ns/1ps
module sac_clk_div
  import sac_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  sac_div_if.div dif
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic src_tick;
  logic tick_q;
  logic [DIV_W-1:0] cnt_q;

  // Oscillator must stay at or below a quarter of clk_i to be seen
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= dif.fast_osc_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lvl_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  assign src_tick = dif.burst_mode_enable ?
                    (s2_q && s3_q && !lvl_q) : 1'b1;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (src_tick) begin
        if (cnt_q >= dif.conversion_clock_divider) begin
          cnt_q <= '0;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign dif.tick = tick_q;
endmodule : sac_clk_div

// ### logic/sac_ctrl.sv
// Converter control: bus registers, sequencer and analog selects
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int RES_BITS = RES_BITS_DEF,
  parameter int TRACK_CLKS = TRACK_CLKS_DEF
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic fast_osc_i,
  input wire logic [RES_BITS-1:0] result_i,
  output logic conv_clk_en_o,
  output logic track_o,
  output logic convert_o,
  output logic [1:0] ref_sel_o,
  output logic ref_level_o,
  output logic int_ref_en_o,
  output logic [1:0] gnd_src_o,
  output logic [4:0] mux_ch_o,
  output logic mux_connect_o,
  output logic irq_o
);
  if (RES_BITS < 1 || RES_BITS > 16 || TRACK_CLKS < 1 ||
      TRACK_CLKS > 16) begin : g_bad_param
    $error("sac_ctrl: RES_BITS and TRACK_CLKS must be 1 to 16");
  end

  localparam logic [CNT_W-1:0] TRK_LAST = CNT_W'(TRACK_CLKS - 1);
  localparam logic [CNT_W-1:0] CNV_LAST = CNT_W'(RES_BITS - 1);

  function automatic logic chan_defined(input logic [4:0] c);
    chan_defined = (c <= CH_EXT_LAST) ||
                   (c >= CH_TEMP && c <= CH_GND) ||
                   (c == CH_P2) || (c >= CH_DP);
  endfunction : chan_defined

  sac_div_if dif ();

  logic ap_valid;
  logic wr_q;
  logic [7:0] waddr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_d;
  logic wr_ctrl;
  logic wr_ref;
  logic wr_mux;
  logic wr_iclr;
  logic wr_ien;
  logic bme_q;
  logic [DIV_W-1:0] div_q;
  logic [1:0] ref_q;
  logic gnd_sel_q;
  logic lvl_q;
  logic [4:0] mux_q;
  logic [IRQ_W-1:0] ien_q;
  logic [IRQ_W-1:0] istat_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [RES_BITS-1:0] result_q;
  logic [15:0] done_cnt_q;
  sac_state_t state_q;
  sac_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic start;
  logic conv_last;
  logic [1:0] lat_ref_q;
  logic lat_gnd_q;
  logic lat_lvl_q;
  logic [4:0] lat_mux_q;
  logic lat_conn_q;
  logic [1:0] nref;
  logic ngnd;
  logic [4:0] nmux;
  logic [1:0] gnd_d;
  logic [1:0] gnd_q;
  logic iref_q;

  // Zero wait state slave; every transfer answers OKAY
  assign ap_valid = hsel_i && htrans_i[1] && hready_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_q <= 1'b0;
      waddr_q <= '0;
    end else begin
      wr_q <= ap_valid && hwrite_i && (haddr_i[31:8] == '0);
      if (ap_valid) begin
        waddr_q <= haddr_i[7:0];
      end
    end
  end

  assign wr_ctrl = wr_q && (waddr_q == ADDR_CTRL);
  assign wr_ref = wr_q && (waddr_q == ADDR_REF);
  assign wr_mux = wr_q && (waddr_q == ADDR_MUX);
  assign wr_iclr = wr_q && (waddr_q == ADDR_ICLR);
  assign wr_ien = wr_q && (waddr_q == ADDR_IEN);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bme_q <= RST_BME;
      div_q <= DIV_RST;
    end else if (wr_ctrl) begin
      bme_q <= hwdata_i[CTRL_BME_BIT];
      div_q <= hwdata_i[CTRL_DIV_LSB +: DIV_W];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ref_q <= REF_RST;
      gnd_sel_q <= GND_SEL_RST;
      lvl_q <= LVL_RST;
    end else if (wr_ref) begin
      ref_q <= hwdata_i[REF_SEL_LSB +: 2];
      gnd_sel_q <= hwdata_i[REF_GND_BIT];
      lvl_q <= hwdata_i[REF_LVL_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mux_q <= MUX_RST;
    end else if (wr_mux) begin
      mux_q <= hwdata_i[MUX_LSB +: 5];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ien_q <= IEN_RST;
    end else if (wr_ien) begin
      ien_q <= hwdata_i[IRQ_W-1:0];
    end
  end

  // Read data settle in the address phase, stand in the data phase
  always_comb begin
    rd_d = '0;
    case (haddr_i[7:0])
      ADDR_CTRL: begin
        rd_d[CTRL_BME_BIT] = bme_q;
        rd_d[CTRL_BUSY_BIT] = (state_q != ST_IDLE);
        rd_d[CTRL_DIV_LSB +: DIV_W] = div_q;
      end
      ADDR_REF: begin
        rd_d[REF_SEL_LSB +: 2] = ref_q;
        rd_d[REF_GND_BIT] = gnd_sel_q;
        rd_d[REF_LVL_BIT] = lvl_q;
      end
      ADDR_MUX: rd_d[MUX_LSB +: 5] = mux_q;
      ADDR_DATA: rd_d[RES_BITS-1:0] = result_q;
      ADDR_ISTAT: rd_d[IRQ_W-1:0] = istat_q;
      ADDR_IEN: rd_d[IRQ_W-1:0] = ien_q;
      ADDR_COUNT: rd_d[15:0] = done_cnt_q;
      default: rd_d = '0;
    endcase
    if (haddr_i[31:8] != '0) begin
      rd_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hrdata_q <= '0;
    end else if (ap_valid && !hwrite_i) begin
      hrdata_q <= rd_d;
    end
  end

  // A start while busy is dropped, not queued
  assign start = wr_ctrl && hwdata_i[CTRL_BUSY_BIT] &&
                 (state_q == ST_IDLE);

  assign dif.burst_mode_enable = bme_q;
  assign dif.conversion_clock_divider = div_q;
  assign dif.fast_osc_raw = fast_osc_i;
  assign conv_clk_en_o = dif.tick;

  sac_clk_div u_div (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .dif(dif)
  );

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    conv_last = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_TRACK;
          cnt_d = '0;
        end
      end
      ST_TRACK: begin
        if (dif.tick) begin
          if (cnt_q == TRK_LAST) begin
            state_d = ST_CONV;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      ST_CONV: begin
        if (dif.tick) begin
          if (cnt_q == CNV_LAST) begin
            state_d = ST_IDLE;
            conv_last = 1'b1;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign track_o = (state_q == ST_TRACK);
  assign convert_o = (state_q == ST_CONV);

  // Reference, ground and input settings freeze at start; divider and burst mode stay live
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lat_ref_q <= REF_RST;
      lat_gnd_q <= GND_SEL_RST;
      lat_lvl_q <= LVL_RST;
      lat_mux_q <= MUX_RST;
      lat_conn_q <= 1'b0;
    end else if (start) begin
      lat_ref_q <= ref_q;
      lat_gnd_q <= gnd_sel_q;
      lat_lvl_q <= lvl_q;
      lat_mux_q <= mux_q;
      lat_conn_q <= chan_defined(mux_q) &&
                    (mux_q != CH_NONE);
    end
  end

  assign ref_sel_o = lat_ref_q;
  assign ref_level_o = lat_lvl_q;
  assign mux_ch_o = lat_mux_q;
  assign mux_connect_o = lat_conn_q;

  assign nref = start ? ref_q : lat_ref_q;
  assign ngnd = start ? gnd_sel_q : lat_gnd_q;
  assign nmux = start ? mux_q : lat_mux_q;

  always_comb begin
    if (state_d == ST_TRACK && nmux == CH_TEMP) begin
      gnd_d = GND_CHIP;
    end else if (state_d == ST_CONV && nref == REF_INT) begin
      gnd_d = GND_CHIP;
    end else if (ngnd) begin
      gnd_d = GND_APIN;
    end else begin
      gnd_d = GND_PIN;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gnd_q <= GND_PIN;
      iref_q <= 1'b0;
    end else begin
      gnd_q <= gnd_d;
      iref_q <= (state_d != ST_IDLE) && (nref == REF_INT);
    end
  end

  assign gnd_src_o = gnd_q;
  assign int_ref_en_o = iref_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      result_q <= '0;
      done_cnt_q <= '0;
    end else if (conv_last) begin
      result_q <= result_i;
      done_cnt_q <= done_cnt_q + 1'b1;
    end
  end

  // Hardware set outranks a clear in the same cycle
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_DONE_BIT] = conv_last;
    irq_set[IRQ_RSVD_BIT] = start && !chan_defined(mux_q);
    irq_clr = wr_iclr ? hwdata_i[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      istat_q <= '0;
    end else begin
      istat_q <= (istat_q & ~irq_clr) | irq_set;
    end
  end

  assign irq_o = |(istat_q & ien_q);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_conv_end;
    convert_o && dif.tick && (cnt_q == CNV_LAST);
  endsequence

  sequence s_idle_after;
    !convert_o && !track_o && istat_q[IRQ_DONE_BIT];
  endsequence

  property p_start;
    start |=> track_o && !convert_o;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not enter tracking");

  property p_done;
    s_conv_end |=> s_idle_after;
  endproperty
  a_done: assert property (p_done)
    else $error("conversion end did not flag completion");

  property p_div_zero;
    (!bme_q && div_q == '0) |=> dif.tick;
  endproperty
  a_div_zero: assert property (p_div_zero)
    else $error("undivided system clock missed a tick");

  property p_div_gap;
    (dif.tick && div_q != '0) |=> !dif.tick;
  endproperty
  a_div_gap: assert property (p_div_gap)
    else $error("divided clock ticked twice in a row");

  property p_iref;
    int_ref_en_o == ((track_o || convert_o) && ref_sel_o == REF_INT);
  endproperty
  a_iref: assert property (p_iref)
    else $error("internal reference enable wrong");

  property p_cfg_load;
    start |=> (ref_level_o == $past(lvl_q)) &&
              (ref_sel_o == $past(ref_q)) && (mux_ch_o == $past(mux_q));
  endproperty
  a_cfg_load: assert property (p_cfg_load)
    else $error("settings not taken at start");

  property p_cfg_hold;
    (convert_o && $past(convert_o)) |->
      $stable(mux_ch_o) && $stable(ref_sel_o) && $stable(ref_level_o);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("settings moved during a conversion");

  property p_ana_gnd;
    (convert_o && ref_sel_o != REF_INT && lat_gnd_q) |->
      gnd_src_o == GND_APIN;
  endproperty
  a_ana_gnd: assert property (p_ana_gnd)
    else $error("analog ground pin not used");

  property p_temp_gnd;
    (track_o && mux_ch_o == CH_TEMP) |-> gnd_src_o == GND_CHIP;
  endproperty
  a_temp_gnd: assert property (p_temp_gnd)
    else $error("temperature sampling off chip ground");

  property p_iref_gnd;
    (convert_o && ref_sel_o == REF_INT) |-> gnd_src_o == GND_CHIP;
  endproperty
  a_iref_gnd: assert property (p_iref_gnd)
    else $error("internal reference conversion off chip ground");

  property p_ext_ch;
    (track_o && mux_ch_o <= CH_EXT_LAST) |-> mux_connect_o;
  endproperty
  a_ext_ch: assert property (p_ext_ch)
    else $error("external input not connected");

  property p_int_ch;
    (track_o && mux_ch_o >= CH_TEMP && mux_ch_o <= CH_GND) |->
      mux_connect_o;
  endproperty
  a_int_ch: assert property (p_int_ch)
    else $error("internal source not connected");

  property p_none_ch;
    (track_o && mux_ch_o == CH_NONE) |-> !mux_connect_o;
  endproperty
  a_none_ch: assert property (p_none_ch)
    else $error("no-connection code connected");
endmodule : sac_ctrl

// ### bench/sac_core_model.sv
// Behavioural converter core that answers the control block
`timescale 1ns/1ps
module sac_core_model #(
  parameter int W = 12
) (
  input wire logic clk_i,
  input wire logic convert_i,
  input wire logic [W-1:0] value_i,
  output logic [W-1:0] result_o
);
  logic [W-1:0] junk_q;

  initial begin
    junk_q = '0;
  end

  // Outside a conversion the result is not held, so it toggles every cycle
  always @(posedge clk_i) begin
    junk_q <= ~junk_q;
  end

  assign result_o = convert_i ? value_i : junk_q;
endmodule : sac_core_model

// ### bench/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
  import sac_pkg::*;
  logic clk_i, srst_i, hsel_i, hwrite_i, fast_osc_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0] htrans_i, ref_sel_o, gnd_src_o;
  logic [2:0] hsize_i;
  logic [11:0] result_i, value;
  logic hreadyout_o, hresp_o, conv_clk_en_o, track_o, convert_o;
  logic ref_level_o, int_ref_en_o, mux_connect_o, irq_o;
  logic [4:0] mux_ch_o;
  int n_mismatch, cmp_count, cyc, osc_cnt;

  sac_ctrl #(.RES_BITS(12), .TRACK_CLKS(4)) DUT (
    .clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .fast_osc_i(fast_osc_i),
    .result_i(result_i), .conv_clk_en_o(conv_clk_en_o), .track_o(track_o),
    .convert_o(convert_o), .ref_sel_o(ref_sel_o), .ref_level_o(ref_level_o),
    .int_ref_en_o(int_ref_en_o), .gnd_src_o(gnd_src_o),
    .mux_ch_o(mux_ch_o), .mux_connect_o(mux_connect_o), .irq_o(irq_o)
  );

  sac_core_model #(.W(12)) CORE (
    .clk_i(clk_i), .convert_i(convert_o), .value_i(value),
    .result_o(result_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Fast oscillator at one eighth of the system clock
  always @(posedge clk_i) begin
    osc_cnt <= (osc_cnt + 1) % 4;
    if (osc_cnt == 3) fast_osc_i <= ~fast_osc_i;
  end

  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // Whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    hsize_i <= 3'b010;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'b00;
    hsel_i <= 1'b0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    chk("hresp", 32'h0, {31'h0, hresp_o});
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    chk(nm, e, rd);
  endtask : rchk

  // Clock cycles between two conversion clock pulses
  task automatic tick_gap(output int g);
    while (conv_clk_en_o !== 1'b1) @(posedge clk_i);
    @(posedge clk_i);
    g = 1;
    while (conv_clk_en_o !== 1'b1) begin
      @(posedge clk_i);
      g++;
    end
  endtask : tick_gap

  initial begin
    int g, rf, gs, lv, dv, bm, ie;
    logic rsv;
    logic [31:0] cw;
    int exp_res[$];
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'b00;
    hwrite_i = 1'b0;
    hsize_i = 3'b010;
    hwdata_i = 32'h0;
    fast_osc_i = 1'b0;
    value = 12'h0;
    osc_cnt = 0;
    cyc = 0;
    n_mismatch = 0;
    cmp_count = 0;
    srst_i = 1'b1;
    void'($urandom(52334));
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    chk("rst_mux_ch", 32'h1f, {27'h0, mux_ch_o});
    chk("rst_connect", 32'h0, {31'h0, mux_connect_o});
    rchk("rst_ctrl", ADDR_CTRL, 32'h1f00);
    rchk("rst_ref", ADDR_REF, 32'h1);
    rchk("rst_mux", ADDR_MUX, 32'h1f);
    rchk("rst_ien", ADDR_IEN, 32'h0);
    rchk("rst_istat", ADDR_ISTAT, 32'h0);
    rchk("unmapped", 8'h20, 32'h0);
    rchk("iclr_read", ADDR_ICLR, 32'h0);
    // Every input code, reserved ones included on purpose
    for (int c = 0; c < 32; c++) begin
      rf = $urandom % 4;
      gs = $urandom % 2;
      lv = $urandom % 2;
      dv = $urandom % 3;
      ie = $urandom % 4;
      bm = (c % 8 == 5) ? 1 : 0;
      rsv = (c == 15) || (c >= 20 && c <= 23) || (c >= 25 && c <= 27);
      cw = 32'((dv << 8) | 2 | bm);
      exp_res.push_back($urandom % 4096);
      value <= 12'(exp_res[$]);
      wr(ADDR_REF, 32'((lv << 3) | (gs << 2) | rf));
      wr(ADDR_MUX, 32'(c));
      wr(ADDR_IEN, 32'(ie));
      wr(ADDR_CTRL, cw);
      while (track_o !== 1'b1) @(posedge clk_i);
      @(posedge clk_i);
      chk("mux_ch", 32'(c), {27'h0, mux_ch_o});
      chk("connect", 32'(!rsv && c != 31), {31'h0, mux_connect_o});
      chk("ref_sel", 32'(rf), {30'h0, ref_sel_o});
      chk("ref_level", 32'(lv), {31'h0, ref_level_o});
      chk("int_ref_trk", 32'(rf == 3), {31'h0, int_ref_en_o});
      chk("gnd_trk", 32'((c == 16) ? 2 : gs), {30'h0, gnd_src_o});
      tick_gap(g);
      chk("tick_gap", 32'(bm ? 8 * (dv + 1) : dv + 1), 32'(g));
      while (convert_o !== 1'b1) @(posedge clk_i);
      @(posedge clk_i);
      chk("gnd_conv", 32'((rf == 3) ? 2 : gs), {30'h0, gnd_src_o});
      chk("int_ref_conv", 32'(rf == 3), {31'h0, int_ref_en_o});
      // New code and a second start while busy must not disturb this one
      wr(ADDR_MUX, 32'(c ^ 1));
      wr(ADDR_CTRL, cw);
      rchk("ctrl_busy", ADDR_CTRL, cw);
      chk("mux_hold", 32'(c), {27'h0, mux_ch_o});
      while (convert_o === 1'b1) @(posedge clk_i);
      rchk("data", ADDR_DATA, 32'(exp_res.pop_front()));
      rchk("status", ADDR_ISTAT, {30'h0, rsv, 1'b1});
      chk("irq", 32'((ie & {rsv, 1'b1}) != 0), {31'h0, irq_o});
      chk("int_ref_off", 32'h0, {31'h0, int_ref_en_o});
      wr(ADDR_ICLR, 32'h3);
      rchk("status_clr", ADDR_ISTAT, 32'h0);
      chk("irq_clr", 32'h0, {31'h0, irq_o});
    end
    rchk("count", ADDR_COUNT, 32'h20);
    test_done();
  end
endmodule : tb_top
